// ---- logic/sdb_pkg.sv ----
package sdb_pkg;

  // ===========================================================
  // widths
  localparam int DQ_W     = 16;
  localparam int BA_W     = 2;
  localparam int COL_W    = 8;
  localparam int ADDR_W   = 13;
  localparam int NBANK    = 4;
  localparam int AP_BIT   = 10;
  localparam int MEM_AW   = BA_W + COL_W;
  localparam int WORD_W   = BA_W + COL_W + DQ_W;
  localparam int BUF_DEPTH = 2;
  localparam int CNT_W    = 8;

  // ===========================================================
  // command codes on cs_b, ras_b, cas_b, we_b
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_STOP  = 4'h6;
  localparam logic [3:0] CMD_PRE   = 4'h2;

  // ===========================================================
  // burst length and cas latency selects
  localparam logic [2:0] BL_PAGE   = 3'h7;
  localparam logic [1:0] CL_3      = 2'h3;
  localparam logic [COL_W-1:0] PAGE_MASK = 8'hff;
  localparam logic [COL_W-1:0] COL_ONE   = 8'h01;

  // ===========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TRP_NS        = 18;
  localparam int TWR_NS        = 15;
  localparam int TRP_RAW  = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TWR_RAW  = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] TRP_CYC =
    CNT_W'((TRP_RAW < 1) ? 1 : TRP_RAW);
  localparam logic [CNT_W-1:0] TWR_CYC =
    CNT_W'((TWR_RAW < 1) ? 1 : TWR_RAW);

  // ===========================================================
  // burst state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b100
  } sdb_burst_type;

endpackage

// ---- logic/sdb_stream_if.sv ----
`timescale 1ns/1ns
interface sdb_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- logic/sdb_fifo.sv ----
`timescale 1ns/1ns
module sdb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  sdb_stream_if.snk in_if,
  sdb_stream_if.src out_if
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW:0]   FULL = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wptr_reg, wptr_next;
  logic [PW-1:0]    rptr_reg, rptr_next;
  logic [PW:0]      cnt_reg, cnt_next;
  logic             do_wr, do_rd;

  // ===========================================================
  // handshakes
  assign in_if.ready  = (cnt_reg != FULL);
  assign out_if.valid = (cnt_reg != '0);
  assign out_if.data  = mem_reg[rptr_reg];
  assign do_wr = in_if.valid & in_if.ready;
  assign do_rd = out_if.valid & out_if.ready;

  // ===========================================================
  // pointers
  always_comb begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    cnt_next  = cnt_reg;
    if (do_wr) begin
      wptr_next = (wptr_reg == LAST) ? '0 : wptr_reg + 1'b1;
    end
    if (do_rd) begin
      rptr_next = (rptr_reg == LAST) ? '0 : rptr_reg + 1'b1;
    end
    if (do_wr && !do_rd) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (do_rd && !do_wr) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg  <= cnt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wptr_reg] <= in_if.data;
    end
  end
endmodule

// ---- logic/sdb_array.sv ----
`timescale 1ns/1ns
module sdb_array (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  sdb_stream_if.snk                        wr_if,
  input  wire logic                        rd_req,
  input  wire logic [sdb_pkg::MEM_AW-1:0]  rd_addr,
  output logic      [sdb_pkg::DQ_W-1:0]    rd_data
);
  logic [sdb_pkg::DQ_W-1:0] mem_reg [2**sdb_pkg::MEM_AW];
  logic [sdb_pkg::DQ_W-1:0] rd_data_reg, rd_data_next;

  // ===========================================================
  // single port: a read stalls the write stream
  assign wr_if.ready = ~rd_req;
  assign rd_data     = rd_data_reg;

  always_comb begin
    rd_data_next = rd_data_reg;
    if (rd_req) begin
      rd_data_next = mem_reg[rd_addr];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_if.valid && wr_if.ready) begin
      mem_reg[wr_if.data[sdb_pkg::WORD_W-1:sdb_pkg::DQ_W]] <=
        wr_if.data[sdb_pkg::DQ_W-1:0];
    end
  end
endmodule

// ---- logic/sdb_burst.sv ----
// Behaviour
// - read precharge stops fetches cas_latency-1 early
// - explicit precharge cuts page bursts and fixed bursts without auto precharge
// - burst stop ends read without auto precharge
// - first write word taken with write command
// - finished fixed write ignores further input data
// - page write wraps to column zero, continues
// - new write cuts old, its data new
// - writes every clock to any bank
// - read stops write input from its edge
// - auto precharge write recovery time plus precharge time
// - burst stop drops coincident write word
// - write carries bank, column, auto precharge choice
// - mask blanks read output two clocks later
// - read data valid cas_latency after read
`timescale 1ns/1ns
module sdb_burst (
  input  wire logic                        CLK,
  input  wire logic                        RST_B,
  input  wire logic                        SDRAM_CLK,
  input  wire logic                        CS_B,
  input  wire logic                        RAS_B,
  input  wire logic                        CAS_B,
  input  wire logic                        WE_B,
  input  wire logic [sdb_pkg::BA_W-1:0]    BA,
  input  wire logic [sdb_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic                        DQM,
  input  wire logic [sdb_pkg::DQ_W-1:0]    DQ_IN,
  input  wire logic [2:0]                  BURST_LEN_SEL,
  input  wire logic [1:0]                  CAS_LAT,
  output logic      [sdb_pkg::DQ_W-1:0]    DQ_OUT,
  output logic                             DQ_OE,
  output logic      [sdb_pkg::NBANK-1:0]   BANK_BUSY,
  output logic                             WBUF_READY
);
  localparam int PIN_W = 3 + 2 + 1 + 4 + sdb_pkg::BA_W + sdb_pkg::ADDR_W
                         + 1 + sdb_pkg::DQ_W;

  // ===========================================================
  // pin synchronisers
  logic [PIN_W-1:0]           pin_s1_reg, pin_s2_reg;
  logic                       lclk_s3_reg;
  logic [2:0]                 bls;
  logic [1:0]                 cl;
  logic                       lclk;
  logic [3:0]                 cmd;
  logic [sdb_pkg::BA_W-1:0]   ba;
  logic [sdb_pkg::ADDR_W-1:0] addr;
  logic                       dqm;
  logic [sdb_pkg::DQ_W-1:0]   dq;
  logic                       edge_hit;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_s1_reg  <= '0;
      pin_s2_reg  <= '0;
      lclk_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg  <= {BURST_LEN_SEL, CAS_LAT, SDRAM_CLK,
                      CS_B, RAS_B, CAS_B, WE_B, BA, ADDR, DQM, DQ_IN};
      pin_s2_reg  <= pin_s1_reg;
      lclk_s3_reg <= lclk;
    end
  end

  assign {bls, cl, lclk, cmd, ba, addr, dqm, dq} = pin_s2_reg;
  assign edge_hit = lclk & ~lclk_s3_reg;

  // ===========================================================
  // write buffer and array
  sdb_stream_if #(.W(sdb_pkg::WORD_W)) push_if ();
  sdb_stream_if #(.W(sdb_pkg::WORD_W)) drain_if ();

  logic                        push_v_reg, push_v_next;
  logic [sdb_pkg::WORD_W-1:0]  push_d_reg, push_d_next;
  logic                        fetch_reg, fetch_next;
  logic [sdb_pkg::MEM_AW-1:0]  faddr_reg, faddr_next;
  logic                        rd_req;
  logic [sdb_pkg::DQ_W-1:0]    rd_data;

  assign push_if.valid = push_v_reg;
  assign push_if.data  = push_d_reg;
  assign WBUF_READY    = push_if.ready;
  // reads wait until buffered writes have landed
  assign rd_req = fetch_reg & ~drain_if.valid & ~push_v_reg;

  sdb_fifo #(
    .WIDTH (sdb_pkg::WORD_W),
    .DEPTH (sdb_pkg::BUF_DEPTH)
  ) u_fifo (
    .clk    (CLK),
    .rst_b  (RST_B),
    .in_if  (push_if),
    .out_if (drain_if)
  );

  sdb_array u_array (
    .clk     (CLK),
    .rst_b   (RST_B),
    .wr_if   (drain_if),
    .rd_req  (rd_req),
    .rd_addr (faddr_reg),
    .rd_data (rd_data)
  );

  // ===========================================================
  // command decode
  logic cmd_rd, cmd_wr, cmd_stop, cmd_pre, pre_cmd;
  logic [sdb_pkg::COL_W-1:0] bl_mask;
  logic                      cont_cmd;

  assign cmd_rd   = (cmd == sdb_pkg::CMD_READ);
  assign cmd_wr   = (cmd == sdb_pkg::CMD_WRITE);
  assign cmd_stop = (cmd == sdb_pkg::CMD_STOP);
  assign cmd_pre  = (cmd == sdb_pkg::CMD_PRE);
  assign pre_cmd  = edge_hit & cmd_pre;
  assign cont_cmd = (bls == sdb_pkg::BL_PAGE);
  assign bl_mask  = cont_cmd ? sdb_pkg::PAGE_MASK :
                    sdb_pkg::COL_W'((9'h001 << bls[1:0]) - 9'h001);

  // ===========================================================
  // burst state
  localparam logic [1:0] CL_ONE = 2'h1;
  localparam logic [1:0] CL_TWO = 2'h2;

  sdb_pkg::sdb_burst_type     st_reg, st_next;
  logic [sdb_pkg::BA_W-1:0]   bank_reg, bank_next;
  logic [sdb_pkg::COL_W-1:0]  col_reg, col_next;
  logic [sdb_pkg::COL_W-1:0]  mask_reg, mask_next;
  logic [sdb_pkg::COL_W-1:0]  rem_reg, rem_next;
  logic                       cont_reg, cont_next;
  logic                       ap_reg, ap_next;
  logic                       fetch_now;
  logic                       push_now;
  logic [sdb_pkg::BA_W-1:0]   acc_bank;
  logic [sdb_pkg::COL_W-1:0]  acc_col;
  logic [sdb_pkg::COL_W-1:0]  start_col;
  logic [sdb_pkg::COL_W-1:0]  step_col;
  logic [sdb_pkg::CNT_W-1:0]  wr_pre_val;
  logic [sdb_pkg::CNT_W-1:0]  cur_pre_val;
  logic [sdb_pkg::CNT_W-1:0]  new_pre_val;
  logic [sdb_pkg::NBANK-1:0]  pre_load;
  logic [sdb_pkg::CNT_W-1:0]  pre_val;

  // write recovery then precharge period
  assign wr_pre_val  = sdb_pkg::TWR_CYC + sdb_pkg::TRP_CYC;
  assign cur_pre_val = (st_reg == sdb_pkg::ST_WR) ? wr_pre_val :
                       sdb_pkg::TRP_CYC;
  assign new_pre_val = cmd_wr ? wr_pre_val : sdb_pkg::TRP_CYC;
  assign start_col   = addr[sdb_pkg::COL_W-1:0];
  // column walk wraps inside the burst, or the whole page
  assign step_col    = (col_reg & ~mask_reg) |
                       ((col_reg + sdb_pkg::COL_ONE) & mask_reg);

  always_comb begin
    st_next   = st_reg;
    bank_next = bank_reg;
    col_next  = col_reg;
    mask_next = mask_reg;
    rem_next  = rem_reg;
    cont_next = cont_reg;
    ap_next   = ap_reg;
    fetch_now = 1'b0;
    push_now  = 1'b0;
    acc_bank  = bank_reg;
    acc_col   = col_reg;
    pre_load  = '0;
    pre_val   = sdb_pkg::TRP_CYC;
    if (edge_hit) begin
      if (cmd_rd || cmd_wr) begin
        // a new access cuts the running burst
        if (st_reg != sdb_pkg::ST_IDLE && ap_reg) begin
          pre_load[bank_reg] = 1'b1;
          pre_val            = cur_pre_val;
        end
        bank_next = ba;
        acc_bank  = ba;
        acc_col   = start_col;
        mask_next = bl_mask;
        rem_next  = bl_mask;
        cont_next = cont_cmd;
        ap_next   = addr[sdb_pkg::AP_BIT] & ~cont_cmd;
        col_next  = (start_col & ~bl_mask) |
                    ((start_col + sdb_pkg::COL_ONE) & bl_mask);
        fetch_now = cmd_rd;
        push_now  = cmd_wr & ~dqm;
        st_next   = cmd_rd ? sdb_pkg::ST_RD : sdb_pkg::ST_WR;
        if (bl_mask == '0 && !cont_cmd) begin
          st_next = sdb_pkg::ST_IDLE;
          if (addr[sdb_pkg::AP_BIT]) begin
            pre_load[ba] = 1'b1;
            pre_val      = new_pre_val;
          end
        end
      end else if (cmd_stop) begin
        // stop only honoured without auto precharge
        if (st_reg != sdb_pkg::ST_IDLE && !ap_reg) begin
          st_next = sdb_pkg::ST_IDLE;
        end
      end else if (pre_cmd) begin
        if (addr[sdb_pkg::AP_BIT]) begin
          pre_load = '1;
        end else begin
          pre_load[ba] = 1'b1;
        end
        // explicit precharge cuts its own bank's burst
        if (st_reg != sdb_pkg::ST_IDLE && !ap_reg &&
            (addr[sdb_pkg::AP_BIT] || ba == bank_reg)) begin
          st_next = sdb_pkg::ST_IDLE;
        end
      end else begin
        unique case (st_reg)
          sdb_pkg::ST_IDLE: begin
            // finished burst: input words are dropped
            st_next = sdb_pkg::ST_IDLE;
          end
          sdb_pkg::ST_RD, sdb_pkg::ST_WR: begin
            fetch_now = (st_reg == sdb_pkg::ST_RD);
            push_now  = (st_reg == sdb_pkg::ST_WR) & ~dqm;
            col_next  = step_col;
            rem_next  = rem_reg - sdb_pkg::COL_ONE;
            if (!cont_reg && rem_reg == sdb_pkg::COL_ONE) begin
              st_next = sdb_pkg::ST_IDLE;
              if (ap_reg) begin
                pre_load[bank_reg] = 1'b1;
                pre_val            = cur_pre_val;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg   <= sdb_pkg::ST_IDLE;
      bank_reg <= '0;
      col_reg  <= '0;
      mask_reg <= '0;
      rem_reg  <= '0;
      cont_reg <= 1'b0;
      ap_reg   <= 1'b0;
    end else begin
      st_reg   <= st_next;
      bank_reg <= bank_next;
      col_reg  <= col_next;
      mask_reg <= mask_next;
      rem_reg  <= rem_next;
      cont_reg <= cont_next;
      ap_reg   <= ap_next;
    end
  end

  // ===========================================================
  // data path and read pipeline
  logic [1:0]                 cl_eff;
  logic [2:0]                 vpipe_reg, vpipe_next;
  logic [1:0]                 hist_reg, hist_next;
  logic [sdb_pkg::DQ_W-1:0]   dp0_reg, dp0_next;
  logic [sdb_pkg::DQ_W-1:0]   dp1_reg, dp1_next;
  logic                       oe_reg, oe_next;
  logic [sdb_pkg::DQ_W-1:0]   dout_reg, dout_next;

  assign cl_eff = (cl == '0) ? CL_ONE : cl;
  assign DQ_OE  = oe_reg;
  assign DQ_OUT = dout_reg;

  always_comb begin
    push_v_next = (push_v_reg & ~push_if.ready) | push_now;
    push_d_next = push_now ? {acc_bank, acc_col, dq} : push_d_reg;
    fetch_next  = (fetch_reg & ~rd_req) | fetch_now;
    faddr_next  = fetch_now ? {acc_bank, acc_col} : faddr_reg;
    vpipe_next  = vpipe_reg;
    hist_next   = hist_reg;
    dp0_next    = dp0_reg;
    dp1_next    = dp1_reg;
    oe_next     = oe_reg;
    dout_next   = dout_reg;
    if (edge_hit) begin
      vpipe_next = {vpipe_reg[1:0], fetch_now};
      hist_next  = {hist_reg[0], dqm};
      dp0_next   = rd_data;
      dp1_next   = dp0_reg;
      // word fetched cas_latency edges ago, mask two edges ago
      oe_next    = vpipe_reg[cl_eff - CL_ONE] & ~hist_reg[1];
      dout_next  = (cl_eff == CL_ONE) ? rd_data :
                   (cl_eff == CL_TWO) ? dp0_reg : dp1_reg;
      if (cmd_wr) begin
        // write takes the data pins back at once
        vpipe_next = '0;
        oe_next    = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      push_v_reg <= 1'b0;
      push_d_reg <= '0;
      fetch_reg  <= 1'b0;
      faddr_reg  <= '0;
      vpipe_reg  <= '0;
      hist_reg   <= '0;
      dp0_reg    <= '0;
      dp1_reg    <= '0;
      oe_reg     <= 1'b0;
      dout_reg   <= '0;
    end else begin
      push_v_reg <= push_v_next;
      push_d_reg <= push_d_next;
      fetch_reg  <= fetch_next;
      faddr_reg  <= faddr_next;
      vpipe_reg  <= vpipe_next;
      hist_reg   <= hist_next;
      dp0_reg    <= dp0_next;
      dp1_reg    <= dp1_next;
      oe_reg     <= oe_next;
      dout_reg   <= dout_next;
    end
  end

  // ===========================================================
  // per bank precharge counters
  generate
    for (genvar g = 0; g < sdb_pkg::NBANK; g++) begin : g_bank
      logic [sdb_pkg::CNT_W-1:0] cnt_reg, cnt_next;

      always_comb begin
        cnt_next = cnt_reg;
        if (edge_hit && pre_load[g]) begin
          cnt_next = pre_val;
        end else if (edge_hit && cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end

      assign BANK_BUSY[g] = (cnt_reg != '0);
    end
  endgenerate
endmodule

// ---- dv/sdb_burst_sva.sv ----
`timescale 1ns/1ns
module sdb_burst_sva (
  input wire logic                        CLK,
  input wire logic                        RST_B,
  input wire logic                        SDRAM_CLK,
  input wire logic                        CS_B,
  input wire logic                        RAS_B,
  input wire logic                        CAS_B,
  input wire logic                        WE_B,
  input wire logic [sdb_pkg::ADDR_W-1:0]  ADDR,
  input wire logic                        DQ_OE,
  input wire logic [sdb_pkg::NBANK-1:0]   BANK_BUSY
);
  // ===========================================================
  // link edge and age counters
  logic       lk_reg;
  logic [7:0] rd_age_reg;
  logic [7:0] lk_age_reg;
  logic [3:0] c;
  logic       e;
  assign c = {CS_B, RAS_B, CAS_B, WE_B};
  assign e = SDRAM_CLK & ~lk_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lk_reg     <= 1'b1;
      rd_age_reg <= 8'hff;
      lk_age_reg <= 8'hff;
    end else begin
      lk_reg     <= SDRAM_CLK;
      rd_age_reg <= (e && c == sdb_pkg::CMD_READ) ? 8'h00 :
                    rd_age_reg + {7'h0, rd_age_reg != 8'hff};
      lk_age_reg <= e ? 8'h00 : lk_age_reg + {7'h0, lk_age_reg != 8'hff};
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ===========================================================
  // assertions
  write_hiz_a: assert property (
    e && c == sdb_pkg::CMD_WRITE |-> ##[1:12] !DQ_OE)
    else $error("output kept after write");
  read_out_a: assert property (
    e && c == sdb_pkg::CMD_READ |-> ##[50:90] DQ_OE)
    else $error("no read output");
  out_cause_a: assert property (
    $rose(DQ_OE) |-> rd_age_reg inside {[8'h28:8'h5a]})
    else $error("output not cas latency after read");
  out_edge_a: assert property (
    $changed(DQ_OE) |-> lk_age_reg < 8'h0a)
    else $error("output moved between link edges");
  stop_end_a: assert property (
    e && c == sdb_pkg::CMD_STOP |-> ##[61:90] !DQ_OE)
    else $error("read not stopped");
  pre_end_a: assert property (
    e && c == sdb_pkg::CMD_PRE && !ADDR[sdb_pkg::AP_BIT]
    |-> ##[61:90] !DQ_OE)
    else $error("read not cut by precharge");
  pre_busy_a: assert property (
    e && c == sdb_pkg::CMD_PRE |-> ##[1:12] |BANK_BUSY)
    else $error("bank not busy after precharge");
  busy_end_a: assert property (
    $rose(|BANK_BUSY) |-> ##[1:200] BANK_BUSY == 4'h0)
    else $error("bank busy too long");
endmodule
bind sdb_burst sdb_burst_sva chk (
  .CLK       (CLK),
  .RST_B     (RST_B),
  .SDRAM_CLK (SDRAM_CLK),
  .CS_B      (CS_B),
  .RAS_B     (RAS_B),
  .CAS_B     (CAS_B),
  .WE_B      (WE_B),
  .ADDR      (ADDR),
  .DQ_OE     (DQ_OE),
  .BANK_BUSY (BANK_BUSY)
);

// ---- dv/sdb_ctrl_model.sv ----
`timescale 1ns/1ns
module sdb_ctrl_model (
  input  wire logic        clk,
  input  wire logic        sclk,
  output logic [3:0]       cmd,
  output logic [1:0]       ba,
  output logic [12:0]      addr,
  output logic             dqm,
  output logic [15:0]      dq
);
  // ===========================================================
  // one command per link cycle, launched in its low half
  initial begin
    cmd = 4'h7;
    ba = 2'h0;
    addr = 13'h0;
    dqm = 1'b0;
    dq = 16'h0;
  end
  task automatic step(logic [3:0] c, logic [1:0] b, logic [12:0] a,
                      logic mk, logic [15:0] d, logic drv);
    @(negedge sclk);
    @(posedge clk);
    cmd <= c;
    ba <= b;
    addr <= a;
    dqm <= mk;
    dq <= drv ? d : ~dq;
  endtask
endmodule

// ---- dv/sdb_burst_bench.sv ----
`timescale 1ns/1ns
module sdb_burst_bench;
  localparam logic [3:0] NOP = 4'h7;
  logic        clk;
  logic        rst_b;
  logic        sclk;
  logic        dqm;
  logic        oe;
  logic [3:0]  cmd;
  logic [3:0]  busy;
  logic [2:0]  bl;
  logic [1:0]  ba;
  logic [12:0] addr;
  logic [15:0] dq;
  logic [15:0] q;
  logic        wbuf;
  logic [15:0] mem [1024];
  logic        seen [1024];
  int          miscompares;
  int          checked;
  int          seed;
  // ===========================================================
  // design and controller model
  sdb_burst uut (.CLK(clk), .RST_B(rst_b), .SDRAM_CLK(sclk),
    .CS_B(cmd[3]), .RAS_B(cmd[2]), .CAS_B(cmd[1]), .WE_B(cmd[0]),
    .BA(ba), .ADDR(addr), .DQM(dqm), .DQ_IN(dq), .BURST_LEN_SEL(bl),
    .CAS_LAT(sdb_pkg::CL_3), .DQ_OUT(q), .DQ_OE(oe), .BANK_BUSY(busy),
    .WBUF_READY(wbuf));
  sdb_ctrl_model m (.clk(clk), .sclk(sclk), .cmd(cmd), .ba(ba),
    .addr(addr), .dqm(dqm), .dq(dq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    sclk = 1'b0;
    #3;
    forever #80 sclk = ~sclk;
  end
  // ===========================================================
  // checks and transfers
  task automatic chk_w(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_b(string n, logic e, logic g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask
  function automatic logic exp_oe(int s, logic [3:0] cut);
    return s > 3 && (cut == NOP || s == 4);
  endfunction
  task automatic wr(logic [1:0] b, logic [7:0] c, int n, logic [3:0] mk,
                    logic stop);
    logic [15:0] d;
    for (int k = 0; k < n; k++) begin
      d = 16'($random(seed));
      m.step(k == 0 ? sdb_pkg::CMD_WRITE : NOP, b, {5'h0, c}, mk[k], d, 1);
      if (!mk[k]) begin
        mem[{b, c + 8'(k)}] = d;
        seen[{b, c + 8'(k)}] = 1'b1;
      end
    end
    if (stop) m.step(sdb_pkg::CMD_STOP, b, 13'h0, 1'b0, ~d, 1'b1);
  endtask
  task automatic rd(logic [1:0] b, logic [7:0] c, logic [3:0] cut);
    logic [9:0] a;
    m.step(sdb_pkg::CMD_READ, b, {5'h0, c}, 1'b0, 16'h0, 1'b0);
    for (int s = 1; s < 8; s++) begin
      m.step(s == 1 ? cut : NOP, b, 13'h0, 1'b0, 16'h0, 1'b0);
      #1;
      a = {b, c[7:2], c[1:0] + 2'(s - 4)};
      chk_b("dq_oe", exp_oe(s, cut), oe);
      if (exp_oe(s, cut) && seen[a]) chk_w("dq_out", mem[a], q);
      if (cut == sdb_pkg::CMD_PRE && s == 2) chk_b("bank_busy", 1'b1, busy[b]);
    end
  endtask
  task automatic results;
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ===========================================================
  // main sequence and watchdog
  initial begin
    seed = 94361;
    for (int i = 0; i < 1024; i++) seen[i] = 1'b0;
    rst_b = 1'b0;
    bl = 3'h2;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(2'(i), 8'(i * 16), 4, 4'h0, 1'b0);
      m.step(NOP, 2'h0, 13'h0, 1'b0, 16'($random(seed)), 1'b1);
    end
    for (int i = 0; i < 8; i++)
      wr(2'(i), 8'(i * 16), 1 + {$random(seed)} % 4, 4'($random(seed)),
         1'($random(seed)));
    for (int i = 0; i < 8; i++) rd(2'(i), 8'(i * 16), NOP);
    rd(2'h0, 8'h00, sdb_pkg::CMD_STOP);
    rd(2'h1, 8'h10, sdb_pkg::CMD_PRE);
    chk_b("bank_busy", 1'b0, busy[1]);
    @(posedge clk) bl <= sdb_pkg::BL_PAGE;
    wr(2'h0, 8'hfe, 3, 4'h0, 1'b0);
    bl <= 3'h2;
    rd(2'h0, 8'h00, NOP);
    rd(2'h0, 8'hfc, NOP);
    chk_b("wbuf_ready", 1'b1, wbuf);
    results();
  end
  initial begin
    #300000;
    miscompares++;
    results();
  end
endmodule
